// ===== core/ufm_serial_port.sv
// Serial port: 8/9-bit frames, address filter, control and data registers
// Summary of operation
// RQ1 - Control bit 7 picks 8-bit frame (0) or 9-bit frame (1).
// RQ2 - 8-bit frame: low start, eight data bits LSB first, one stop.
// RQ3 - 9-bit frame: start, eight data LSB first, ninth bit, stop.
// RQ4 - Ninth transmit bit is control bit 3, ignored in 8-bit frames.
// RQ5 - Writing the data buffer location starts sending that byte.
// RQ6 - Transmit done flag sets at the start of the stop bit.
// RQ7 - Receiver takes frames only while control bit 4 is set.
// RQ8 - 8-bit: stop bit to bit 2; load if flag clear and filter passes.
// RQ9 - 9-bit: ninth bit to bit 2; load if flag clear, filter passes.
// RQ10 - Failed load leaves buffer, ninth bit and receive flag unchanged.
// RQ11 - On overrun the first byte stays and later frames are dropped.
// RQ12 - Receive flag sets when the stop bit of an accepted frame samples.
// RQ13 - Hardware never clears the flags; software clears them by writing.
// RQ14 - One interrupt request while either flag is set and enabled.
// RQ15 - Control bit 6 reads as one; writes to it do nothing.
// RQ16 - Master sends ninth bit one for address, zero for data bytes.
// RQ17 - Slave software clears filter on address match, sets it after.
// RQ18 - Control register at 0x98 page 0, bit-addressable, resets to 0x40.
// RQ19 - Each bit period lasts two timer overflows.
// RQ20 - Receive bit timer reloads when a start edge is seen.
// RQ21 - Data buffer reads return received byte; writes go to transmit.
// RQ22 - Line idles high; start on falling edge, sample mid-bit; the code samples data and stop bits at the start of each bit, half a bit after mid-bit.
module ufm_serial_port (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  input  wire ufm_pkg::ufm_sfr_s sfr_i,
  output logic [7:0]            sfr_rdata_o,
  input  wire logic             tx_ovf_i,
  input  wire logic             t1_tick_i,
  input  wire logic [7:0]       baud_reload_value_i,
  input  wire logic             int_enable_i,
  output logic                  irq_o,
  output logic                  tx_space_o,
  input  wire logic             serial_in_pin_i,
  output logic                  serial_out_pin_o
);

  ufm_pkg::ufm_state_s s_q, s_d;

  logic       fifo_in_valid;
  logic       fifo_out_valid;
  logic       fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic       ctl_wr;
  logic       ctl_bwr;
  logic       data_wr;
  logic       ctl_rd;
  logic       data_rd;
  logic       rovf;
  logic       rx_bit_end;
  logic       tx_bit_end;
  logic       rx_accept;
  logic       rx_finish;
  logic       ti_set;
  logic       bit9;

  // Address decode shared by every access kind
  function automatic logic sfr_hit(input ufm_pkg::ufm_sfr_s r,
                                   input logic [7:0] a);
    sfr_hit = (r.addr == a) && (r.page == ufm_pkg::SFR_PAGE);
  endfunction

  // Register access strobes
  assign ctl_wr  = sfr_i.wr && sfr_hit(sfr_i, ufm_pkg::CTL_ADDR); // RQ18
  assign ctl_bwr = sfr_i.bit_wr && sfr_hit(sfr_i, ufm_pkg::CTL_ADDR);
  assign data_wr = sfr_i.wr && sfr_hit(sfr_i, ufm_pkg::DATA_ADDR);
  assign ctl_rd  = sfr_i.rd && sfr_hit(sfr_i, ufm_pkg::CTL_ADDR);
  assign data_rd = sfr_i.rd && sfr_hit(sfr_i, ufm_pkg::DATA_ADDR);

  // Writes to the data location feed the transmit FIFO
  assign fifo_in_valid  = data_wr; // RQ5 RQ21
  assign fifo_out_ready = (s_q.tst == ufm_pkg::TX_IDLE);

  // Transmit FIFO; full shows on tx_space_o so software can hold off
  ufm_fifo #(
    .W (ufm_pkg::DATA_W),
    .D (ufm_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (tx_space_o),
    .in_data_i   (sfr_i.wdata),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out_data)
  );

  // Bit boundaries: every second timer overflow ends a bit
  assign tx_bit_end = tx_ovf_i && s_q.tph; // RQ19
  assign rovf       = t1_tick_i && (s_q.rtmr == ufm_pkg::TMR_TOP);
  assign rx_bit_end = rovf && s_q.rph; // RQ19

  // Stop-bit verdict; the filter checks stop bit or ninth bit by mode
  assign bit9 = s_q.ctl[ufm_pkg::B_MODE] ? s_q.rb9 : serial_in_pin_i;
  assign rx_finish = (s_q.rst == ufm_pkg::RX_STOP) && rx_bit_end;
  assign rx_accept = rx_finish && !s_q.ctl[ufm_pkg::B_RI] &&
                     (!s_q.ctl[ufm_pkg::B_MCE] || bit9); // RQ8 RQ9 RQ11
  assign ti_set = tx_bit_end &&
                  ((s_q.tst == ufm_pkg::TX_NINTH) ||
                   (s_q.tst == ufm_pkg::TX_DATA &&
                    s_q.tcnt == ufm_pkg::LAST_BIT &&
                    !s_q.ctl[ufm_pkg::B_MODE])); // RQ6

  // Next state of the whole port
  always_comb begin
    s_d     = s_q;
    s_d.rxp = serial_in_pin_i;

    // Software writes first, so a hardware set below wins the same cycle
    if (ctl_wr) begin
      s_d.ctl = sfr_i.wdata & ufm_pkg::CTL_WMASK; // RQ13 RQ15
    end else if (ctl_bwr && sfr_i.bit_sel != 3'(ufm_pkg::B_ONE)) begin
      s_d.ctl[sfr_i.bit_sel] = sfr_i.wdata[0]; // RQ15
    end

    // Transmitter
    if (tx_ovf_i && s_q.tst != ufm_pkg::TX_IDLE) begin
      s_d.tph = !s_q.tph;
    end
    case (s_q.tst)
      ufm_pkg::TX_IDLE: begin
        s_d.txd = 1'b1; // RQ22
        if (fifo_out_valid) begin
          s_d.tst  = ufm_pkg::TX_START;
          s_d.tsh  = fifo_out_data;
          s_d.tph  = 1'b0;
          s_d.tcnt = ufm_pkg::CNT_ZERO;
          s_d.txd  = 1'b0; // RQ2 RQ3
        end
      end
      ufm_pkg::TX_START: begin
        if (tx_bit_end) begin
          s_d.tst = ufm_pkg::TX_DATA;
          s_d.txd = s_q.tsh[0]; // RQ2
        end
      end
      ufm_pkg::TX_DATA: begin
        if (tx_bit_end) begin
          s_d.tsh  = {1'b0, s_q.tsh[7:1]};
          s_d.tcnt = s_q.tcnt + ufm_pkg::CNT_ONE;
          s_d.txd  = s_q.tsh[1];
          if (s_q.tcnt == ufm_pkg::LAST_BIT) begin
            if (s_q.ctl[ufm_pkg::B_MODE]) begin // RQ1
              s_d.tst = ufm_pkg::TX_NINTH;
              s_d.txd = s_q.ctl[ufm_pkg::B_TB9]; // RQ4
            end else begin
              s_d.tst = ufm_pkg::TX_STOP;
              s_d.txd = 1'b1;
            end
          end
        end
      end
      ufm_pkg::TX_NINTH: begin
        if (tx_bit_end) begin
          s_d.tst = ufm_pkg::TX_STOP;
          s_d.txd = 1'b1; // RQ3
        end
      end
      ufm_pkg::TX_STOP: begin
        if (tx_bit_end) begin
          s_d.tst = ufm_pkg::TX_IDLE;
        end
      end
      default: begin
        s_d.tst = ufm_pkg::TX_IDLE;
        s_d.txd = 1'b1;
      end
    endcase
    if (ti_set) begin
      s_d.ctl[ufm_pkg::B_TI] = 1'b1; // RQ6 RQ13
    end

    // Receive bit timer: a private copy of the reload timer
    if (t1_tick_i) begin
      s_d.rtmr = rovf ? baud_reload_value_i : s_q.rtmr + ufm_pkg::TMR_ONE;
    end
    if (rovf && s_q.rst != ufm_pkg::RX_IDLE) begin
      s_d.rph = !s_q.rph;
    end

    // Receiver
    case (s_q.rst)
      ufm_pkg::RX_IDLE: begin
        // Falling edge while enabled starts a frame
        if (s_q.ctl[ufm_pkg::B_REN] && s_q.rxp &&
            !serial_in_pin_i) begin // RQ7 RQ22
          s_d.rst  = ufm_pkg::RX_START;
          s_d.rtmr = baud_reload_value_i; // RQ20
          s_d.rph  = 1'b0;
          s_d.rcnt = ufm_pkg::CNT_ZERO;
        end
      end
      ufm_pkg::RX_START: begin
        // First overflow lands mid start bit; a glitch goes back idle
        if (rovf && !s_q.rph) begin
          if (serial_in_pin_i) begin
            s_d.rst = ufm_pkg::RX_IDLE;
          end else begin
            s_d.rst = ufm_pkg::RX_DATA; // RQ22
          end
        end
      end
      ufm_pkg::RX_DATA: begin
        if (rx_bit_end) begin
          s_d.rsh  = {serial_in_pin_i, s_q.rsh[7:1]}; // RQ2
          s_d.rcnt = s_q.rcnt + ufm_pkg::CNT_ONE;
          if (s_q.rcnt == ufm_pkg::LAST_BIT) begin
            s_d.rst = s_q.ctl[ufm_pkg::B_MODE] ? ufm_pkg::RX_NINTH
                                               : ufm_pkg::RX_STOP;
          end
        end
      end
      ufm_pkg::RX_NINTH: begin
        if (rx_bit_end) begin
          s_d.rb9 = serial_in_pin_i; // RQ3
          s_d.rst = ufm_pkg::RX_STOP;
        end
      end
      ufm_pkg::RX_STOP: begin
        if (rx_bit_end) begin
          s_d.rst = ufm_pkg::RX_IDLE;
        end
      end
      default: begin
        s_d.rst = ufm_pkg::RX_IDLE;
      end
    endcase

    // Refused frames leave buffer, bit 2 and flag alone
    if (rx_accept) begin // RQ10 RQ11
      s_d.rbuf               = s_q.rsh;
      s_d.ctl[ufm_pkg::B_RB9] = bit9; // RQ8 RQ9
      s_d.ctl[ufm_pkg::B_RI]  = 1'b1; // RQ12
    end
    s_d.ctl[ufm_pkg::B_ONE] = 1'b0;

    // Registered read data; unmapped addresses read zero
    if (ctl_rd) begin
      s_d.rdata = s_q.ctl | ufm_pkg::CTL_RESET; // RQ15
    end else if (data_rd) begin
      s_d.rdata = s_q.rbuf; // RQ21
    end else begin
      s_d.rdata = ufm_pkg::RD_ZERO;
    end

    // One request for both flags, so software must poll to tell them apart
    s_d.irq = int_enable_i &&
              (s_d.ctl[ufm_pkg::B_TI] || s_d.ctl[ufm_pkg::B_RI]); // RQ14
  end

  // State register
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q      <= '0;
      s_q.txd  <= 1'b1; // RQ22
      s_q.rxp  <= 1'b1;
      s_q.rtmr <= ufm_pkg::TMR_TOP;
    end else begin
      s_q <= s_d; // RQ18
    end
  end

  // Every top output is a register bit, so nothing glitches at the pins
  assign sfr_rdata_o      = s_q.rdata;
  assign irq_o            = s_q.irq;
  assign serial_out_pin_o = s_q.txd;

  // Checks sampled on the system clock, quiet while reset is held
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Transmit line shape and flag timing
  a_tx_idle_high: assert property ( // RQ22
    s_q.tst == ufm_pkg::TX_IDLE && $past(s_q.tst) == ufm_pkg::TX_IDLE
    |-> serial_out_pin_o)
    else $error("line not high while idle");
  a_start_bit_low: assert property ( // RQ2
    s_q.tst == ufm_pkg::TX_START |-> !serial_out_pin_o)
    else $error("start bit not low");
  a_ninth_from_ctl: assert property ( // RQ4
    $rose(s_q.tst == ufm_pkg::TX_NINTH)
    |-> serial_out_pin_o == $past(s_q.ctl[ufm_pkg::B_TB9]))
    else $error("ninth bit not taken from control bit 3");
  a_ti_at_stop: assert property ( // RQ6
    $rose(s_q.tst == ufm_pkg::TX_STOP) |-> s_q.ctl[ufm_pkg::B_TI])
    else $error("transmit flag not set at stop start");

  // Receiver gating, overrun and sticky flags
  a_rx_gated: assert property ( // RQ7
    s_q.rst == ufm_pkg::RX_IDLE && !s_q.ctl[ufm_pkg::B_REN]
    |=> s_q.rst == ufm_pkg::RX_IDLE)
    else $error("frame started while disabled");
  a_overrun_keep: assert property ( // RQ11
    s_q.ctl[ufm_pkg::B_RI] |=> $stable(s_q.rbuf))
    else $error("receive buffer overwritten");
  a_ri_on_accept: assert property ( // RQ12
    rx_accept |=> s_q.ctl[ufm_pkg::B_RI] && s_q.rbuf == $past(s_q.rsh))
    else $error("accepted frame not latched");
  a_flag_sticky: assert property ( // RQ13
    s_q.ctl[ufm_pkg::B_RI] && !ctl_wr && !ctl_bwr
    |=> s_q.ctl[ufm_pkg::B_RI])
    else $error("receive flag cleared by hardware");
  // Request is registered from the next-state flags, so it changes in the same cycle as the flags
  a_irq_follow: assert property ( // RQ14
    int_enable_i && (s_q.ctl[ufm_pkg::B_TI] || s_q.ctl[ufm_pkg::B_RI])
    && !ctl_wr && !ctl_bwr |=> irq_o)
    else $error("interrupt not raised");
  a_bit6_one: assert property ( // RQ15
    ctl_rd |=> sfr_rdata_o[ufm_pkg::B_ONE])
    else $error("bit 6 not read as one");
  a_ti_sticky: assert property ( // RQ13
    s_q.ctl[ufm_pkg::B_TI] && !ctl_wr && !ctl_bwr
    |=> s_q.ctl[ufm_pkg::B_TI])
    else $error("transmit flag cleared by hardware");

  // Receive verdict: what bit 2 takes, and what a refusal must leave
  a_rb9_ninth: assert property ( // RQ9
    rx_accept && s_q.ctl[ufm_pkg::B_MODE]
    |=> s_q.ctl[ufm_pkg::B_RB9] == $past(s_q.rb9))
    else $error("bit 2 not loaded from ninth bit");
  a_rb9_stop: assert property ( // RQ8
    rx_accept && !s_q.ctl[ufm_pkg::B_MODE]
    |=> s_q.ctl[ufm_pkg::B_RB9] == $past(serial_in_pin_i))
    else $error("bit 2 not loaded from stop bit");
  a_refused_hold: assert property ( // RQ10
    rx_finish && !rx_accept && !ctl_wr && !ctl_bwr
    |=> $stable(s_q.rbuf) && $stable(s_q.ctl[ufm_pkg::B_RB9])
        && $stable(s_q.ctl[ufm_pkg::B_RI]))
    else $error("refused frame changed receive state");
  a_rx_reload: assert property ( // RQ20
    s_q.rst == ufm_pkg::RX_START && $past(s_q.rst) == ufm_pkg::RX_IDLE
    |-> s_q.rtmr == $past(baud_reload_value_i))
    else $error("receive timer not reloaded at start");

  // Main scenarios the bench is expected to reach
  c_tx_frame: cover property ($rose(s_q.tst == ufm_pkg::TX_STOP));
  c_rx_accept: cover property (rx_accept);
  c_rx_refused: cover property (rx_finish && !rx_accept);
  c_fifo_full: cover property (!tx_space_o);
endmodule // ufm_serial_port

// ===== core/ufm_pkg.sv
// Package: constants, enums and carrier structs of the serial port block
package ufm_pkg;

  // Special function register map
  localparam logic [7:0] CTL_ADDR   = 8'h98;
  localparam logic [7:0] DATA_ADDR  = 8'h99;
  localparam logic [3:0] SFR_PAGE   = 4'h0;
  localparam logic [7:0] CTL_RESET  = 8'h40;
  localparam logic [7:0] CTL_WMASK  = 8'hbf;
  localparam logic [7:0] RD_ZERO    = 8'h00;

  // Control register bit positions
  localparam int unsigned B_MODE = 7;
  localparam int unsigned B_ONE  = 6;
  localparam int unsigned B_MCE  = 5;
  localparam int unsigned B_REN  = 4;
  localparam int unsigned B_TB9  = 3;
  localparam int unsigned B_RB9  = 2;
  localparam int unsigned B_TI   = 1;
  localparam int unsigned B_RI   = 0;

  // Frame and buffer shape
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam logic [3:0]  LAST_BIT   = 4'h7;
  localparam logic [3:0]  CNT_ZERO   = 4'h0;
  localparam logic [3:0]  CNT_ONE    = 4'h1;
  localparam logic [7:0]  TMR_TOP    = 8'hff;
  localparam logic [7:0]  TMR_ONE    = 8'h01;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_START = 3'b001,
    TX_DATA  = 3'b010,
    TX_NINTH = 3'b011,
    TX_STOP  = 3'b100
  } ufm_tx_e;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b000,
    RX_START = 3'b001,
    RX_DATA  = 3'b010,
    RX_NINTH = 3'b011,
    RX_STOP  = 3'b100
  } ufm_rx_e;

  // CPU special function register access
  typedef struct packed {
    logic [7:0] addr;
    logic [3:0] page;
    logic       wr;
    logic       rd;
    logic       bit_wr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } ufm_sfr_s;

  // Whole state of the port, registered as one word
  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] rbuf;
    logic [7:0] rdata;
    logic       irq;
    ufm_tx_e    tst;
    logic [3:0] tcnt;
    logic [7:0] tsh;
    logic       tph;
    logic       txd;
    ufm_rx_e    rst;
    logic [3:0] rcnt;
    logic [7:0] rsh;
    logic       rph;
    logic [7:0] rtmr;
    logic       rxp;
    logic       rb9;
  } ufm_state_s;

endpackage : ufm_pkg

// ===== core/ufm_fifo.sv
// Transmit byte FIFO with valid/ready on both sides
module ufm_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 8
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int unsigned AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
    logic                spc;
  } ufm_fifo_st_s;

  ufm_fifo_st_s s_q, s_d;
  logic push, pop;

  // Space is its own flop so the ready output carries no compare logic
  assign in_ready_o  = s_q.spc;
  assign out_valid_o = (s_q.cnt != '0);
  assign out_data_o  = s_q.mem[s_q.rp];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Pointers wrap because depth is a power of two
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = in_data_i;
      s_d.wp          = s_q.wp + AW'(1);
    end
    if (pop) begin
      s_d.rp = s_q.rp + AW'(1);
    end
    s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    s_d.spc = (s_d.cnt != (AW+1)'(D));
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q     <= '0;
      s_q.spc <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_fifo_no_over: assert property (
    in_ready_o == (s_q.cnt != (AW+1)'(D)))
    else $error("ready does not match fill level");
  a_fifo_count: assert property (push && !pop |=> s_q.cnt == $past(s_q.cnt) + 1)
    else $error("count not raised on push");
endmodule // ufm_fifo

// ===== dv/ufm_remote_node.sv
// Remote serial node: sends frames to the port and decodes its output
module ufm_remote_node (
  input  wire logic sys_clk_i,
  input  wire logic nine_i,
  input  wire logic line_i,
  output logic      line_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // Bit time is two overflows of a 16-cycle timer
  localparam int BIT_CYC = 32;

  logic [7:0] got_byte;
  logic [7:0] sh;
  logic       got_ninth;
  logic       got_stop;
  int         n_frames;

  initial begin
    line_o   = 1'b1;
    n_frames = 0;
  end

  // Holds one level for a whole bit time
  task automatic put_bit(input logic v);
    line_o <= v;
    repeat (BIT_CYC) @(posedge sys_clk_i);
  endtask

  // Start, data LSB first, ninth in 9-bit frames, stop, then idle high
  task automatic send_frame(input logic [7:0] b, input logic nb,
                            input logic sb);
    @(posedge sys_clk_i);
    put_bit(1'b0);
    for (int i = 0; i < 8; i++) begin
      put_bit(b[i]);
    end
    if (nine_i) begin
      put_bit(nb);
    end
    put_bit(sb);
    line_o <= 1'b1;
  endtask

  // Decoder samples mid-bit, so edge jitter of a cycle is harmless
  initial begin
    forever begin
      @(posedge sys_clk_i);
      if (line_i === 1'b0) begin
        repeat (BIT_CYC / 2) @(posedge sys_clk_i);
        if (line_i === 1'b0) begin
          for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge sys_clk_i);
            sh[i] = line_i;
          end
          if (nine_i) begin
            repeat (BIT_CYC) @(posedge sys_clk_i);
            got_ninth = line_i;
          end
          repeat (BIT_CYC) @(posedge sys_clk_i);
          got_stop = line_i;
          got_byte = sh;
          n_frames++;
        end
      end
    end
  end
endmodule // ufm_remote_node

// ===== dv/ufm_serial_port_bench.sv
// Self-checking bench for the serial port block
module ufm_serial_port_bench;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [7:0] CTL = ufm_pkg::CTL_ADDR;
  localparam logic [7:0] DAT = ufm_pkg::DATA_ADDR;

  logic              sys_clk;
  logic              rst_n;
  ufm_pkg::ufm_sfr_s sfr;
  logic [7:0]        sfr_rdata;
  logic              tx_ovf;
  logic              int_en;
  logic              irq;
  logic              tx_space;
  logic              to_dut;
  logic              from_dut;
  logic              nine;
  logic [7:0]        rdat;
  int                miscompares;
  int                n_compared;
  int                n0;

  ufm_serial_port uut (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .sfr_i(sfr),
    .sfr_rdata_o(sfr_rdata), .tx_ovf_i(tx_ovf), .t1_tick_i(1'b1),
    .baud_reload_value_i(8'hf0), .int_enable_i(int_en), .irq_o(irq),
    .tx_space_o(tx_space), .serial_in_pin_i(to_dut),
    .serial_out_pin_o(from_dut)
  );

  ufm_remote_node rn (
    .sys_clk_i(sys_clk), .nine_i(nine), .line_i(from_dut),
    .line_o(to_dut)
  );

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Transmit overflow every 16 cycles: two make one bit
  initial begin
    tx_ovf = 1'b0;
    forever begin
      repeat (15) @(posedge sys_clk);
      tx_ovf <= 1'b1;
      @(posedge sys_clk);
      tx_ovf <= 1'b0;
    end
  end

  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // One register cycle; read data stands one cycle, taken at its last edge
  task automatic sfr_op(logic [7:0] a, logic w, logic b, logic [2:0] s,
                        logic [7:0] d);
    @(posedge sys_clk);
    sfr.addr    <= a;
    sfr.wr      <= w;
    sfr.rd      <= !w && !b;
    sfr.bit_wr  <= b;
    sfr.bit_sel <= s;
    sfr.wdata   <= d;
    @(posedge sys_clk);
    sfr.wr     <= 1'b0;
    sfr.rd     <= 1'b0;
    sfr.bit_wr <= 1'b0;
    @(posedge sys_clk);
    rdat = sfr_rdata;
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    sfr_op(a, 1'b1, 1'b0, 3'h0, d);
  endtask

  task automatic rd(string what, logic [7:0] a, logic [7:0] exp);
    sfr_op(a, 1'b0, 1'b0, 3'h0, 8'h00);
    check(what, exp, rdat);
  endtask

  // Bounded wait for decoded frames from the port
  task automatic wait_frames(int n);
    for (int k = 0; k < 20000 && rn.n_frames < n; k++) begin
      @(posedge sys_clk);
    end
    if (rn.n_frames < n) begin
      $display("Error frame wait expected %0d seen %0d", n, rn.n_frames);
      miscompares++;
      tally_and_finish();
    end
  endtask

  initial begin
    miscompares = 0;
    n_compared  = 0;
    rst_n       = 1'b0;
    sfr         = '0;
    int_en      = 1'b0;
    nine        = 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    // Registers, fixed bit, bit access, unmapped place, interrupt
    rd("ctl reset", CTL, 8'h40);
    wr(CTL, 8'hff);
    int_en <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check("irq set", 8'h01, {7'h0, irq});
    rd("ctl all", CTL, 8'hff);
    wr(CTL, 8'h00);
    repeat (3) @(posedge sys_clk);
    check("irq clr", 8'h00, {7'h0, irq});
    rd("ctl zero", CTL, 8'h40);
    sfr_op(CTL, 1'b0, 1'b1, 3'h6, 8'h00);
    sfr_op(CTL, 1'b0, 1'b1, 3'h4, 8'h01);
    rd("ctl bits", CTL, 8'h50);
    rd("unmapped", 8'h9a, 8'h00);
    $display("test registers done");
    // 8-bit send with ninth bit set, which must not appear
    wr(CTL, 8'h08);
    n0 = rn.n_frames;
    wr(DAT, 8'ha5);
    wait_frames(n0 + 1);
    check("tx byte", 8'ha5, rn.got_byte);
    check("tx stop", 8'h01, {7'h0, rn.got_stop});
    rd("ctl ti", CTL, 8'h4a);
    // 9-bit send, ninth bit both ways
    nine = 1'b1;
    for (int t = 0; t < 2; t++) begin
      wr(CTL, 8'h80 | 8'(t << 3));
      n0 = rn.n_frames;
      wr(DAT, 8'h5a ^ 8'(t));
      wait_frames(n0 + 1);
      check("tx9 byte", 8'h5a ^ 8'(t), rn.got_byte);
      check("tx9 ninth", 8'(t), {7'h0, rn.got_ninth});
    end
    $display("test transmit done");
    // 8-bit receive: disabled, accepted, overrun, bad stop filtered
    nine = 1'b0;
    wr(CTL, 8'h00);
    rn.send_frame(8'h3c, 1'b0, 1'b1);
    rd("rx off", CTL, 8'h40);
    wr(CTL, 8'h10);
    rn.send_frame(8'h3c, 1'b0, 1'b1);
    rd("rx ctl", CTL, 8'h55);
    rd("rx data", DAT, 8'h3c);
    rn.send_frame(8'h55, 1'b0, 1'b1);
    rd("overrun", DAT, 8'h3c);
    rd("ovr ctl", CTL, 8'h55);
    wr(CTL, 8'h30);
    rn.send_frame(8'h66, 1'b0, 1'b0);
    rd("bad stop", CTL, 8'h70);
    rd("bad data", DAT, 8'h3c);
    $display("test receive8 done");
    // Address filter: data rejected, address taken, then data taken
    nine = 1'b1;
    wr(CTL, 8'hb0);
    rn.send_frame(8'h11, 1'b0, 1'b1);
    rd("mp data", CTL, 8'hf0);
    rn.send_frame(8'h22, 1'b1, 1'b1);
    rd("mp addr", CTL, 8'hf5);
    rd("addr val", DAT, 8'h22);
    wr(CTL, 8'h90);
    rn.send_frame(8'h33, 1'b0, 1'b1);
    rd("mp open", CTL, 8'hd1);
    rd("open val", DAT, 8'h33);
    $display("test multiproc done");
    // Fill the FIFO past full; the excess write is dropped
    nine = 1'b0;
    wr(CTL, 8'h00);
    n0 = rn.n_frames;
    for (int i = 0; i < 10; i++) begin
      wr(DAT, 8'h80 + 8'(i));
    end
    check("full", 8'h00, {7'h0, tx_space});
    wait_frames(n0 + 9);
    check("last", 8'h88, rn.got_byte);
    repeat (800) @(posedge sys_clk);
    check("count", 8'(n0 + 9), 8'(rn.n_frames));
    check("space", 8'h01, {7'h0, tx_space});
    $display("test fifo done");
    tally_and_finish();
  end
endmodule // ufm_serial_port_bench
